// >>> logic/rbm_switch.sv
`timescale 1ns/1ns
// How it works
// - Backup mode resets to manual
// - Manual: command brings unit online, ignoring peer
// - Auto-dependent: goes online when peer faults
// - Auto-dependent: any local fault drops both paths
// - Auto-independent: goes online when peer faults
// - Auto-independent: paths released separately
// - Auto-independent: drop only faulted path, keep other
module rbm_switch
    import rbm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic local_fault_ul,
    input wire logic local_fault_dl,
    input wire logic peer_fault,
    input wire logic peer_own_ul,
    input wire logic peer_own_dl,
    output logic own_uplink_path,
    output logic own_downlink_path,
    output logic fault_to_peer,
    output logic irq
);

    // Two-flop synchronisers for the pins from the peer and the fault detectors
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic s_fault_ul;
    logic s_fault_dl;
    logic s_peer_fault;
    logic s_peer_ul;
    logic s_peer_dl;

    // Software state
    logic [1:0] backup_mode;
    logic online;
    logic [EV_WIDTH-1:0] irq_stat;
    logic [EV_WIDTH-1:0] irq_mask;
    logic [EV_WIDTH-1:0] events;
    logic peer_fault_d;

    // Data-phase capture of the AHB address phase
    logic dp_write;
    logic [3:0] dp_addr;
    logic addr_ok;

    // Command strobes decoded from a control write
    logic cmd_online;
    logic cmd_offline;
    logic [31:0] next_rdata;

    // Synchroniser chain; only stage two is read by logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {peer_own_dl, peer_own_ul, peer_fault, local_fault_dl, local_fault_ul};
            sync2 <= sync1;
        end
    end

    assign s_fault_ul = sync2[0];
    assign s_fault_dl = sync2[1];
    assign s_peer_fault = sync2[2];
    assign s_peer_ul = sync2[3];
    assign s_peer_dl = sync2[4];

    // Address phase is taken when selected, NONSEQ and bus ready
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 4'h0;
        end else begin
            // Writes above the decoded window are ignored, as reads return zero there
            dp_write <= addr_ok && hwrite && (haddr[31:4] == 28'h0);
            dp_addr <= haddr[3:0];
        end
    end

    // Slave is zero wait state and always answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Command strobes, one cycle, from the control write data phase
    assign cmd_online = dp_write && (dp_addr == OFF_CTRL) && hwdata[CTRL_GO_ONLINE];
    assign cmd_offline = dp_write && (dp_addr == OFF_CTRL) && hwdata[CTRL_GO_OFFLINE];

    // Backup mode register; reserved code 3 is refused and the mode kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            backup_mode <= MODE_RESET;
        end else if (dp_write && dp_addr == OFF_CTRL
                     && hwdata[CTRL_MODE_LSB+:2] != 2'h3) begin
            backup_mode <= hwdata[CTRL_MODE_LSB+:2];
        end
    end

    // Online state machine of the unit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            online <= 1'b0;
        end else if (cmd_offline) begin
            // Software may always send the unit back offline
            online <= 1'b0;
        end else if (!online) begin
            if (backup_mode == MODE_MANUAL) begin
                // Peer state is not consulted here
                if (cmd_online) online <= 1'b1;
            end else if (backup_mode == MODE_AUTO_DEPENDENT_BACKUP) begin
                if (s_peer_fault) online <= 1'b1;
            end else if (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP) begin
                if (s_peer_fault) online <= 1'b1;
            end
        end
    end

    // Uplink ownership: held while online, dropped per fault policy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_uplink_path <= 1'b0;
        end else if (!online) begin
            own_uplink_path <= 1'b0;
        end else if (backup_mode == MODE_AUTO_DEPENDENT_BACKUP && (s_fault_ul || s_fault_dl)) begin
            own_uplink_path <= 1'b0;
        end else if (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && s_fault_ul) begin
            own_uplink_path <= 1'b0;
        end else if (!own_uplink_path && !s_peer_ul) begin
            own_uplink_path <= 1'b1;
        end
    end

    // Downlink ownership: same policy on the other path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_downlink_path <= 1'b0;
        end else if (!online) begin
            own_downlink_path <= 1'b0;
        end else if (backup_mode == MODE_AUTO_DEPENDENT_BACKUP && (s_fault_ul || s_fault_dl)) begin
            own_downlink_path <= 1'b0;
        end else if (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && s_fault_dl) begin
            own_downlink_path <= 1'b0;
        end else if (!own_downlink_path && !s_peer_dl) begin
            own_downlink_path <= 1'b1;
        end
    end

    // Fault report to the peer lets it take over released paths
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_to_peer <= 1'b0;
        end else begin
            fault_to_peer <= s_fault_ul || s_fault_dl;
        end
    end

    // Event sources: rising edges of online and peer fault, path drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peer_fault_d <= 1'b0;
        end else begin
            peer_fault_d <= s_peer_fault;
        end
    end

    // Uplink goes with either fault when paired, with its own fault when independent
    assign events[EV_UL_RELEASED] = own_uplink_path && online
        && ((backup_mode == MODE_AUTO_DEPENDENT_BACKUP && (s_fault_ul || s_fault_dl))
            || (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && s_fault_ul));
    assign events[EV_DL_RELEASED] = own_downlink_path && online
        && ((backup_mode == MODE_AUTO_DEPENDENT_BACKUP && (s_fault_ul || s_fault_dl))
            || (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && s_fault_dl));
    assign events[EV_PEER_FAULT] = s_peer_fault && !peer_fault_d;

    // Online event: flop of the previous online state
    logic online_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            online_d <= 1'b0;
        end else begin
            online_d <= online;
        end
    end

    // Went-online event on the rising edge of the online state
    assign events[EV_WENT_ONLINE] = online && !online_d;

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            for (int i = 0; i < EV_WIDTH; i++) begin
                if (events[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (dp_write && dp_addr == OFF_IRQ_STAT && hwdata[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask, one enables the matching status bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= MASK_RESET;
        end else if (dp_write && dp_addr == OFF_IRQ_MASK) begin
            irq_mask <= hwdata[EV_WIDTH-1:0];
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read mux, decoded in the address phase; unmapped reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[3:0])
            OFF_CTRL: next_rdata[CTRL_MODE_LSB+:2] = backup_mode;
            OFF_STATUS: begin
                next_rdata[ST_ONLINE] = online;
                next_rdata[ST_OWN_UL] = own_uplink_path;
                next_rdata[ST_OWN_DL] = own_downlink_path;
                next_rdata[ST_PEER_FAULT] = s_peer_fault;
                next_rdata[ST_LOCAL_FAULT_UL] = s_fault_ul;
                next_rdata[ST_LOCAL_FAULT_DL] = s_fault_dl;
            end
            OFF_IRQ_STAT: next_rdata[EV_WIDTH-1:0] = irq_stat;
            OFF_IRQ_MASK: next_rdata[EV_WIDTH-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
        if (haddr[31:4] != 28'h0) begin
            next_rdata = 32'h0000_0000;
        end
    end

    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Mode resets to manual and stays so until written
    chk_mode_reset_manual: assert property (@(posedge hclk)
        $rose(hresetn) |-> backup_mode == MODE_MANUAL)
        else $error("backup mode not manual after reset");

    // Manual online command takes effect next cycle
    chk_manual_cmd_online: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_MANUAL && !online && cmd_online && !cmd_offline) |=> online)
        else $error("manual command did not bring unit online");

    // Manual mode never goes online on peer fault alone
    chk_manual_no_auto: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_MANUAL && !online && !cmd_online) |=> !online)
        else $error("manual mode went online without command");

    // Auto-dependent online on peer fault
    chk_dep_auto_online: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_AUTO_DEPENDENT_BACKUP && !online && s_peer_fault && !cmd_offline) |=> online)
        else $error("auto-dependent did not go online on peer fault");

    // Auto-dependent drops both paths on any fault
    chk_dep_drop_both: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_AUTO_DEPENDENT_BACKUP && (s_fault_ul || s_fault_dl))
        |=> !own_uplink_path && !own_downlink_path)
        else $error("auto-dependent kept a path under fault");

    // Auto-independent online on peer fault
    chk_ind_auto_online: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && !online && s_peer_fault && !cmd_offline) |=> online)
        else $error("auto-independent did not go online on peer fault");

    // Auto-independent keeps downlink when only uplink faults
    chk_ind_keep_other: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && online && !cmd_offline && s_fault_ul && !s_fault_dl
         && own_downlink_path) |=> !own_uplink_path && own_downlink_path)
        else $error("auto-independent released wrong path");

    // Auto-independent downlink fault releases downlink only
    chk_ind_sep_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_mode == MODE_AUTO_INDEPENDENT_BACKUP && online && !cmd_offline && s_fault_dl && !s_fault_ul
         && own_uplink_path) |=> own_uplink_path && !own_downlink_path)
        else $error("auto-independent did not release paths separately");

    // Path is claimed only while the peer has released it
    chk_claim_after_rel: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(own_uplink_path) |-> !$past(s_peer_ul))
        else $error("uplink claimed while peer owned it");

    // Downlink likewise claimed only while the peer has released it
    chk_claim_dl_rel: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(own_downlink_path) |-> !$past(s_peer_dl))
        else $error("downlink claimed while peer owned it");

endmodule

// >>> common/rbm_pkg.sv
package rbm_pkg;
    // Backup mode encodings, held in the control register
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO_DEPENDENT_BACKUP = 2'h1;
    localparam logic [1:0] MODE_AUTO_INDEPENDENT_BACKUP = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_MANUAL;
    // Register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_GO_ONLINE = 4;
    localparam int CTRL_GO_OFFLINE = 5;
    // Status register fields
    localparam int ST_ONLINE = 0;
    localparam int ST_OWN_UL = 1;
    localparam int ST_OWN_DL = 2;
    localparam int ST_PEER_FAULT = 3;
    localparam int ST_LOCAL_FAULT_UL = 4;
    localparam int ST_LOCAL_FAULT_DL = 5;
    // Interrupt event bits
    localparam int EV_WENT_ONLINE = 0;
    localparam int EV_UL_RELEASED = 1;
    localparam int EV_DL_RELEASED = 2;
    localparam int EV_PEER_FAULT = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // AHB transfer type code for a non-sequential transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> test/rbm_peer_model.sv
`timescale 1ns/1ns
// Partner unit: claims a path that this unit has released, after a set latency
module rbm_peer_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic own_uplink_path,
    input wire logic own_downlink_path,
    input wire logic want_ul,
    input wire logic want_dl,
    input wire logic [3:0] lat,
    output logic peer_own_ul,
    output logic peer_own_dl
);
    logic [3:0] free_ul; // Cycles the uplink has been seen released
    logic [3:0] free_dl; // Cycles the downlink has been seen released

    // Uplink: claim only once released for lat cycles, drop when unwanted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            free_ul <= 4'h0;
            peer_own_ul <= 1'b0;
        end else if (!want_ul) begin
            free_ul <= 4'h0;
            peer_own_ul <= 1'b0;
        end else if (own_uplink_path) begin
            free_ul <= 4'h0;
        end else if (free_ul >= lat) begin
            peer_own_ul <= 1'b1;
        end else begin
            free_ul <= free_ul + 4'h1;
        end
    end

    // Downlink: same handling, kept apart so paths move singly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            free_dl <= 4'h0;
            peer_own_dl <= 1'b0;
        end else if (!want_dl) begin
            free_dl <= 4'h0;
            peer_own_dl <= 1'b0;
        end else if (own_downlink_path) begin
            free_dl <= 4'h0;
        end else if (free_dl >= lat) begin
            peer_own_dl <= 1'b1;
        end else begin
            free_dl <= free_dl + 4'h1;
        end
    end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import rbm_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, fault_to_peer;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] lat;
    logic local_fault_ul, local_fault_dl, peer_fault, peer_own_ul, peer_own_dl;
    logic own_uplink_path, own_downlink_path, want_ul, want_dl;
    int error_cnt, comparisons, cycles;

    rbm_switch rbm_switch_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .local_fault_ul(local_fault_ul), .local_fault_dl(local_fault_dl),
        .peer_fault(peer_fault), .peer_own_ul(peer_own_ul), .peer_own_dl(peer_own_dl),
        .own_uplink_path(own_uplink_path), .own_downlink_path(own_downlink_path),
        .fault_to_peer(fault_to_peer), .irq(irq));
    rbm_peer_model rbm_peer_model_inst (.hclk(hclk), .hresetn(hresetn),
        .own_uplink_path(own_uplink_path), .own_downlink_path(own_downlink_path),
        .want_ul(want_ul), .want_dl(want_dl), .lat(lat),
        .peer_own_ul(peer_own_ul), .peer_own_dl(peer_own_dl));

    // Clock, 8 ns period
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    // Verdict and end of run
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Word comparison
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Single pin comparison
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One AHB single transfer; read data taken at the data phase's closing edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {28'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Reset state of control and status registers, paths, irq and hresp
    task automatic t_reset();
        bus(1'b0, OFF_CTRL, 32'h0);
        chk_word(rd, {30'h0, MODE_MANUAL});
        bus(1'b0, OFF_STATUS, 32'h0);
        chk_word(rd, 32'h0);
        chk_bit(own_uplink_path | own_downlink_path | irq, 1'b0);
        chk_bit(hresp, 1'b0);
    endtask

    // Manual: peer fault ignored, command brings the unit online, faults kept
    task automatic t_manual();
        peer_fault <= 1'b1;
        wait_cyc(10);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk_bit(rd[ST_ONLINE], 1'b0);
        bus(1'b1, OFF_CTRL, 32'h0000_0010);
        wait_cyc(8);
        chk_bit(own_uplink_path & own_downlink_path, 1'b1);
        local_fault_ul <= 1'b1;
        wait_cyc(8);
        chk_bit(own_uplink_path, 1'b1);
        local_fault_ul <= 1'b0;
        peer_fault <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h0000_0020);
        wait_cyc(8);
        chk_bit(own_uplink_path | own_downlink_path, 1'b0);
    endtask

    // Auto-dependent: online on peer fault, one fault drops both, peer takes both
    task automatic t_auto_dependent_backup();
        lat <= 4'h1;
        bus(1'b1, OFF_CTRL, {30'h0, MODE_AUTO_DEPENDENT_BACKUP});
        wait_cyc(8);
        chk_bit(own_uplink_path, 1'b0);
        peer_fault <= 1'b1;
        wait_cyc(8);
        chk_bit(own_uplink_path & own_downlink_path, 1'b1);
        local_fault_dl <= 1'b1;
        wait_cyc(8);
        chk_bit(own_uplink_path | own_downlink_path, 1'b0);
        chk_bit(fault_to_peer, 1'b1);
        want_ul <= 1'b1;
        want_dl <= 1'b1;
        wait_cyc(8);
        chk_bit(peer_own_ul & peer_own_dl, 1'b1);
        local_fault_dl <= 1'b0;
        wait_cyc(8);
        chk_bit(own_uplink_path | own_downlink_path, 1'b0);
        want_ul <= 1'b0;
        want_dl <= 1'b0;
        wait_cyc(10);
        chk_bit(own_uplink_path & own_downlink_path, 1'b1);
    endtask

    // Auto-independent with a slow peer: only the faulted path moves
    task automatic t_auto_independent_backup();
        lat <= 4'h6;
        bus(1'b1, OFF_CTRL, {30'h0, MODE_AUTO_INDEPENDENT_BACKUP} | 32'h0000_0020);
        wait_cyc(10);
        chk_bit(own_uplink_path & own_downlink_path, 1'b1);
        want_ul <= 1'b1;
        want_dl <= 1'b1;
        local_fault_ul <= 1'b1;
        wait_cyc(14);
        chk_bit(own_uplink_path, 1'b0);
        chk_bit(own_downlink_path, 1'b1);
        chk_bit(peer_own_ul & ~peer_own_dl, 1'b1);
        local_fault_ul <= 1'b0;
        want_ul <= 1'b0;
        want_dl <= 1'b0;
        wait_cyc(10);
        chk_bit(own_uplink_path, 1'b1);
    endtask

    // Events, mask, clear by writing one, unmapped place
    task automatic t_irq();
        bus(1'b0, OFF_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h0000_000F);
        chk_bit(irq, 1'b0);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_000F);
        wait_cyc(2);
        chk_bit(irq, 1'b1);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_000F);
        wait_cyc(2);
        chk_bit(irq, 1'b0);
        bus(1'b1, 4'h3, 32'hFFFF_FFFF);
        bus(1'b0, OFF_IRQ_MASK, 32'h0);
        chk_word(rd, 32'h0000_000F);
        bus(1'b1, OFF_CTRL, 32'h0000_0003);
        bus(1'b0, OFF_CTRL, 32'h0);
        chk_word(rd, {30'h0, MODE_AUTO_INDEPENDENT_BACKUP});
    endtask

    // Main sequence
    initial begin
        {hsel, hwrite, local_fault_ul, local_fault_dl, peer_fault, want_ul, want_dl} = 7'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        lat = 4'h1;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        hresetn = 1'b0;
        wait_cyc(5);
        hresetn <= 1'b1;
        t_reset();
        t_manual();
        t_auto_dependent_backup();
        t_auto_independent_backup();
        t_irq();
        summarize();
    end
endmodule
